// >>> design/negotiation_pkg.sv
// constants for the negotiation status and advertisement register bank
package negotiation_pkg;

  localparam int DATA_W = 32;
  localparam int REG_W  = 16;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [11:0] IDX_CONTROL = 12'h200;
  localparam logic [11:0] IDX_STATUS  = 12'h201;
  localparam logic [11:0] IDX_ADV_LOW = 12'h202;
  localparam logic [11:0] IDX_ADV_MID = 12'h203;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] RST_CONTROL = 16'h1000;
  localparam logic [15:0] RST_STATUS  = 16'h0008;
  localparam logic [15:0] RST_ADV_LOW = 16'h0001;
  localparam logic [15:0] RST_ADV_MID = 16'h4000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_ENABLE      = 12;
  localparam int BIT_PAGE_RX     = 6;
  localparam int BIT_DONE        = 5;
  localparam int BIT_FAULT_LATCH = 4;
  localparam int BIT_CAPABLE     = 3;
  localparam int BIT_LINK        = 2;
  localparam int BIT_MORE_PAGES  = 15;
  localparam int BIT_ACK         = 14;
  localparam int BIT_ADV_FAULT   = 13;
  localparam int BIT_FORCE_ROLE  = 12;
  localparam int BIT_PAUSE_HI    = 11;
  localparam int BIT_PAUSE_LO    = 10;
  localparam int BIT_SEL_HI      = 4;
  localparam int BIT_SEL_LO      = 0;
  localparam int BIT_LONG_REACH  = 14;
  localparam int BIT_MASTER      = 4;
  localparam int NONCE_ROLE_BIT  = 4;

  localparam logic [4:0] SELECTOR_ETHERNET = 5'h01;

  // ahb encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'h0;

endpackage

// >>> design/ahb_word_slave.sv
// AHB-Lite slave front end with one wait state per word transfer
`timescale 1ns/1ps
module ahb_word_slave #(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [ADDR_W-3:0] acc_index,
  output logic                   rd_strobe,
  output logic                   wr_strobe,
  output logic      [31:0]       wr_data,
  input  wire logic [31:0]       rd_data
);

  typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_DONE} phase_t;

  phase_t            phase_reg;
  phase_t            phase_next;
  logic              write_reg;
  logic              word_reg;
  logic [ADDR_W-3:0] index_reg;
  logic [31:0]       hrdata_reg;

  wire take = hsel && hready && htrans[1];
  wire is_word = (hsize == negotiation_pkg::HSIZE_WORD);

  always_comb
  begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_IDLE: phase_next = take ? PH_WAIT : PH_IDLE;
      PH_WAIT: phase_next = PH_DONE;
      PH_DONE: phase_next = take ? PH_WAIT : PH_IDLE;
      default: phase_next = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      phase_reg  <= PH_IDLE;
      write_reg  <= 1'b0;
      word_reg   <= 1'b0;
      index_reg  <= '0;
      hrdata_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      if (take && phase_reg != PH_WAIT)
      begin
        write_reg <= hwrite;
        word_reg  <= is_word;
        index_reg <= haddr[ADDR_W-1:2];
      end
      if (rd_strobe)
        hrdata_reg <= rd_data;
    end
  end

  // the wait state lets read data come from a flop and gives hwdata time
  assign hreadyout = (phase_reg != PH_WAIT);
  assign hresp     = negotiation_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_reg;
  assign acc_index = index_reg;
  assign wr_data   = hwdata;
  // sub-word transfers complete without effect
  assign rd_strobe = (phase_reg == PH_WAIT) && word_reg && !write_reg;
  assign wr_strobe = (phase_reg == PH_WAIT) && word_reg && write_reg;

endmodule

// >>> design/autoneg_status_advert_regs.sv
// negotiation status, control and local advertisement registers over AHB-Lite
`timescale 1ns/1ps
module autoneg_status_advert_regs #(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // ****************************************************************
  // register bus
  // ****************************************************************
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // ****************************************************************
  // negotiation engine side
  // ****************************************************************
  input  wire logic              master_role_strap,
  input  wire logic              attempt_start,
  input  wire logic              page_captured,
  input  wire logic              page_is_base,
  input  wire logic              partner_fault_bit,
  input  wire logic              codeword_seen,
  input  wire logic              negotiation_finished,
  input  wire logic              link_ok,
  output logic                   negotiation_enable,
  output logic                   partner_base_valid,
  output logic                   advertise_more_pages,
  output logic                   codeword_acknowledge,
  output logic                   advertise_fault,
  output logic                   forced_role_select,
  output logic      [1:0]        advertise_pause,
  output logic      [4:0]        selector_field,
  output logic                   advertise_long_reach_ability,
  output logic                   advertise_master_role,
  output logic                   nonce_role_bit
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  // indices need twelve bits above the byte offset
  if (ADDR_W < 14 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("ADDR_W must lie between 14 and 32");
  end

  // ****************************************************************
  // bus front end
  // ****************************************************************
  logic [ADDR_W-3:0] acc_index;
  logic              rd_strobe;
  logic              wr_strobe;
  logic [31:0]       wr_data;
  logic [31:0]       rd_data;

  ahb_word_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .clk       (clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .acc_index (acc_index),
    .rd_strobe (rd_strobe),
    .wr_strobe (wr_strobe),
    .wr_data   (wr_data),
    .rd_data   (rd_data)
  );

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic index_hit(input logic [ADDR_W-3:0] idx, input logic [11:0] target);
    index_hit = (idx == {{(ADDR_W-14){1'b0}}, target});
  endfunction

  wire sel_control = index_hit(acc_index, negotiation_pkg::IDX_CONTROL);
  wire sel_status  = index_hit(acc_index, negotiation_pkg::IDX_STATUS);
  wire sel_low     = index_hit(acc_index, negotiation_pkg::IDX_ADV_LOW);
  wire sel_mid     = index_hit(acc_index, negotiation_pkg::IDX_ADV_MID);

  wire wr_control  = wr_strobe && sel_control;
  wire wr_low      = wr_strobe && sel_low;
  wire wr_mid      = wr_strobe && sel_mid;
  // the status read is what clears the latched flags
  wire status_read = rd_strobe && sel_status;

  // ****************************************************************
  // state registers
  // ****************************************************************
  logic       enable_reg;
  logic       page_rx_reg;
  logic       page_rx_next;
  logic       fault_latch_reg;
  logic       fault_latch_next;
  logic       link_latch_reg;
  logic       link_latch_next;
  logic       base_valid_reg;
  logic       base_valid_next;
  logic       ack_reg;
  logic       more_pages_reg;
  logic       adv_fault_reg;
  logic       force_role_reg;
  logic [1:0] pause_reg;
  logic       long_reach_reg;
  logic       master_reg;
  logic       strap_taken_reg;

  // ****************************************************************
  // latched status flags
  // ****************************************************************
  // page flag, set wins over read clear
  assign page_rx_next = page_captured || (page_rx_reg && !status_read);

  assign fault_latch_next = (page_captured && page_is_base && partner_fault_bit)
                            || (fault_latch_reg && !status_read);

  // link latched low, a read reloads the live level
  assign link_latch_next = status_read ? link_ok : (link_latch_reg && link_ok);

  // base page valid after first base page in attempt
  assign base_valid_next = (attempt_start || !enable_reg) ? 1'b0
                           : (base_valid_reg || (page_captured && page_is_base));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      page_rx_reg     <= 1'b0;
      fault_latch_reg <= 1'b0;
      link_latch_reg  <= 1'b0;
      base_valid_reg  <= 1'b0;
      ack_reg         <= 1'b0;
    end
    else
    begin
      page_rx_reg     <= page_rx_next;
      fault_latch_reg <= fault_latch_next;
      link_latch_reg  <= link_latch_next;
      base_valid_reg  <= base_valid_next;
      ack_reg         <= codeword_seen && enable_reg;
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      enable_reg <= negotiation_pkg::RST_CONTROL[negotiation_pkg::BIT_ENABLE];
    else if (wr_control)
      enable_reg <= wr_data[negotiation_pkg::BIT_ENABLE];
  end

  // ****************************************************************
  // advertisement low word
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      more_pages_reg <= negotiation_pkg::RST_ADV_LOW[negotiation_pkg::BIT_MORE_PAGES];
      adv_fault_reg  <= negotiation_pkg::RST_ADV_LOW[negotiation_pkg::BIT_ADV_FAULT];
      force_role_reg <= negotiation_pkg::RST_ADV_LOW[negotiation_pkg::BIT_FORCE_ROLE];
      pause_reg      <= negotiation_pkg::RST_ADV_LOW[negotiation_pkg::BIT_PAUSE_HI:negotiation_pkg::BIT_PAUSE_LO];
    end
    else if (wr_low)
    begin
      more_pages_reg <= wr_data[negotiation_pkg::BIT_MORE_PAGES];
      adv_fault_reg  <= wr_data[negotiation_pkg::BIT_ADV_FAULT];
      force_role_reg <= wr_data[negotiation_pkg::BIT_FORCE_ROLE];
      pause_reg      <= wr_data[negotiation_pkg::BIT_PAUSE_HI:negotiation_pkg::BIT_PAUSE_LO];
    end
  end

  // ****************************************************************
  // advertisement middle word
  // ****************************************************************
  // strap is sampled on the first edge after reset release, never under reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      long_reach_reg  <= negotiation_pkg::RST_ADV_MID[negotiation_pkg::BIT_LONG_REACH];
      master_reg      <= negotiation_pkg::RST_ADV_MID[negotiation_pkg::BIT_MASTER];
      strap_taken_reg <= 1'b0;
    end
    else
    begin
      strap_taken_reg <= 1'b1;
      if (wr_mid)
        long_reach_reg <= wr_data[negotiation_pkg::BIT_LONG_REACH];
      if (!strap_taken_reg)
        master_reg <= master_role_strap;
      else if (wr_mid)
        master_reg <= wr_data[negotiation_pkg::BIT_MASTER];
    end
  end

  // ****************************************************************
  // register images
  // ****************************************************************
  logic [15:0] control_image;
  logic [15:0] status_image;
  logic [15:0] low_image;
  logic [15:0] mid_image;

  // done needs finish, live link and enable
  wire done_live = negotiation_finished && link_ok && enable_reg;

  always_comb
  begin
    control_image = '0;
    control_image[negotiation_pkg::BIT_ENABLE] = enable_reg;
  end

  always_comb
  begin
    status_image = '0;
    status_image[negotiation_pkg::BIT_PAGE_RX]     = page_rx_reg;
    status_image[negotiation_pkg::BIT_DONE]        = done_live;
    status_image[negotiation_pkg::BIT_FAULT_LATCH] = fault_latch_reg;
    status_image[negotiation_pkg::BIT_CAPABLE]     = negotiation_pkg::RST_STATUS[negotiation_pkg::BIT_CAPABLE];
    status_image[negotiation_pkg::BIT_LINK]        = link_latch_reg;
  end

  always_comb
  begin
    low_image = '0;
    low_image[negotiation_pkg::BIT_MORE_PAGES] = more_pages_reg;
    low_image[negotiation_pkg::BIT_ACK]        = ack_reg;
    low_image[negotiation_pkg::BIT_ADV_FAULT]  = adv_fault_reg;
    low_image[negotiation_pkg::BIT_FORCE_ROLE] = force_role_reg;
    low_image[negotiation_pkg::BIT_PAUSE_HI:negotiation_pkg::BIT_PAUSE_LO] = pause_reg;
    low_image[negotiation_pkg::BIT_SEL_HI:negotiation_pkg::BIT_SEL_LO]     = negotiation_pkg::SELECTOR_ETHERNET;
  end

  always_comb
  begin
    mid_image = '0;
    mid_image[negotiation_pkg::BIT_LONG_REACH] = long_reach_reg;
    mid_image[negotiation_pkg::BIT_MASTER]     = master_reg;
  end

  // ****************************************************************
  // read selection
  // ****************************************************************
  // unmapped indices read zero and still answer okay
  wire [15:0] read_word = sel_control ? control_image :
                          sel_status  ? status_image  :
                          sel_low     ? low_image     :
                          sel_mid     ? mid_image     : 16'h0000;

  assign rd_data = {16'h0000, read_word};

  // ****************************************************************
  // engine outputs
  // ****************************************************************
  assign negotiation_enable           = enable_reg;
  assign partner_base_valid           = base_valid_reg;
  assign advertise_more_pages         = more_pages_reg;
  assign codeword_acknowledge         = ack_reg;
  assign advertise_fault              = adv_fault_reg;
  assign forced_role_select           = force_role_reg;
  assign advertise_pause              = pause_reg;
  assign selector_field               = negotiation_pkg::SELECTOR_ETHERNET;
  assign advertise_long_reach_ability = long_reach_reg;
  assign advertise_master_role        = master_reg;
  assign nonce_role_bit               = master_reg;

endmodule

// >>> verification/regs_checker.sv
// concurrent assertions on the negotiation register bank ports
`timescale 1ns/1ps
module regs_checker #(
  parameter int ADDR_W = 16
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              attempt_start,
  input wire logic              page_captured,
  input wire logic              page_is_base,
  input wire logic              partner_fault_bit,
  input wire logic              codeword_seen,
  input wire logic              negotiation_finished,
  input wire logic              link_ok,
  input wire logic              negotiation_enable,
  input wire logic              partner_base_valid,
  input wire logic              codeword_acknowledge,
  input wire logic [4:0]        selector_field,
  input wire logic              advertise_master_role,
  input wire logic              nonce_role_bit
);
  localparam logic [ADDR_W-1:0] STAT_ADDR = ADDR_W'({negotiation_pkg::IDX_STATUS, 2'h0});

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // sequences
  // ****************************************************************
  wire stat_rd = hsel && hready && hreadyout && htrans[1] && !hwrite
                 && hsize == negotiation_pkg::HSIZE_WORD && haddr == STAT_ADDR;

  sequence status_rd;
    stat_rd;
  endsequence
  // a read taken with the event would consume the flag first, so it is excluded
  sequence page_then_rd;
    page_captured && !stat_rd ##[1:2] status_rd;
  endsequence
  sequence fault_then_rd;
    page_captured && page_is_base && partner_fault_bit && !stat_rd ##[1:2] status_rd;
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  page_latch_a: assert property (page_then_rd |-> ##2 hrdata[6])
    else $error("page flag not seen on status read");
  fault_latch_a: assert property (fault_then_rd |-> ##2 hrdata[4])
    else $error("partner fault flag not seen on status read");
  done_live_a: assert property (status_rd |-> ##2
    hrdata[5] == $past(negotiation_finished && link_ok && negotiation_enable))
    else $error("done bit disagrees with finish, link and enable");
  status_fixed_a: assert property (status_rd |-> ##2
    (hrdata[31:7] == '0 && hrdata[3] && hrdata[1:0] == 2'h0))
    else $error("status constant or reserved bits wrong");
  link_low_a: assert property (!link_ok ##0 status_rd |-> ##2 !hrdata[2])
    else $error("link bit high while link down");
  ack_follow_a: assert property ($past(rst_n) |->
    codeword_acknowledge == $past(codeword_seen && negotiation_enable))
    else $error("acknowledge does not follow codeword seen");
  base_valid_a: assert property (page_captured && page_is_base && negotiation_enable && !attempt_start
    |=> partner_base_valid) else $error("base page did not mark partner page valid");
  attempt_clr_a: assert property (attempt_start && !page_captured |=> !partner_base_valid)
    else $error("new attempt left partner page valid");
  enable_off_a: assert property (!negotiation_enable && !page_captured |=> !partner_base_valid)
    else $error("partner page valid while negotiation disabled");
  role_nonce_a: assert property (nonce_role_bit == advertise_master_role)
    else $error("nonce role bit differs from advertised role");
  sel_fixed_a: assert property (selector_field == negotiation_pkg::SELECTOR_ETHERNET)
    else $error("selector field not fixed");
endmodule

bind autoneg_status_advert_regs regs_checker #(.ADDR_W(ADDR_W)) regs_checker_inst (
  .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hrdata, .hreadyout,
  .attempt_start, .page_captured, .page_is_base, .partner_fault_bit, .codeword_seen,
  .negotiation_finished, .link_ok, .negotiation_enable, .partner_base_valid,
  .codeword_acknowledge, .selector_field, .advertise_master_role, .nonce_role_bit
);

// >>> verification/link_engine_model.sv
// behavioural negotiation engine facing a link partner, drives the engine side
`timescale 1ns/1ps
module link_engine_model (
  input wire logic clk,
  output logic     attempt_start,
  output logic     page_captured,
  output logic     page_is_base,
  output logic     partner_fault_bit,
  output logic     codeword_seen,
  output logic     negotiation_finished,
  output logic     link_ok
);
  initial
  begin
    {attempt_start, page_captured, page_is_base, partner_fault_bit} = 4'h0;
    {codeword_seen, negotiation_finished, link_ok} = 3'h0;
  end

  // qualifiers flip after the pulse so a stale value is never mistaken for a hold
  task automatic give_page(input logic base, input logic flt);
    @(posedge clk);
    page_captured <= 1'b1;
    page_is_base <= base;
    partner_fault_bit <= flt;
    codeword_seen <= 1'b1;
    @(posedge clk);
    page_captured <= 1'b0;
    page_is_base <= ~base;
    partner_fault_bit <= ~flt;
  endtask

  task automatic set_line(input logic fin, input logic ok);
    @(posedge clk);
    negotiation_finished <= fin;
    link_ok <= ok;
  endtask

  task automatic new_attempt;
    @(posedge clk);
    attempt_start <= 1'b1;
    codeword_seen <= 1'b0;
    @(posedge clk);
    attempt_start <= 1'b0;
  endtask
endmodule

// >>> verification/autoneg_status_advert_regs_tb_top.sv
// self-checking bench for the negotiation status and advertisement registers
`timescale 1ns/1ps
module autoneg_status_advert_regs_tb_top;
  localparam logic [11:0] STS = negotiation_pkg::IDX_STATUS;
  localparam logic [11:0] ADL = negotiation_pkg::IDX_ADV_LOW;
  localparam logic [11:0] ADM = negotiation_pkg::IDX_ADV_MID;
  localparam logic [11:0] CTL = negotiation_pkg::IDX_CONTROL;

  logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, master_role_strap;
  logic [15:0] haddr;
  logic [1:0]  htrans, advertise_pause;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        attempt_start, page_captured, page_is_base, partner_fault_bit, codeword_seen;
  logic        negotiation_finished, link_ok, negotiation_enable, partner_base_valid;
  logic        advertise_more_pages, codeword_acknowledge, advertise_fault, forced_role_select;
  logic [4:0]  selector_field;
  logic        advertise_long_reach_ability, advertise_master_role, nonce_role_bit;
  int          fail_count, tests_run;

  assign hready = hreadyout;

  autoneg_status_advert_regs autoneg_status_advert_regs_inst (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
    .hreadyout, .hresp, .master_role_strap, .attempt_start, .page_captured, .page_is_base,
    .partner_fault_bit, .codeword_seen, .negotiation_finished, .link_ok, .negotiation_enable,
    .partner_base_valid, .advertise_more_pages, .codeword_acknowledge, .advertise_fault,
    .forced_role_select, .advertise_pause, .selector_field, .advertise_long_reach_ability,
    .advertise_master_role, .nonce_role_bit
  );

  link_engine_model link_engine_model_inst (
    .clk, .attempt_start, .page_captured, .page_is_base, .partner_fault_bit,
    .codeword_seen, .negotiation_finished, .link_ok
  );

  // ****************************************************************
  // bus and compare helpers
  // ****************************************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ready and read data are taken at the rising edge that ends the phase
  task automatic wait_ready(output logic [31:0] d);
    do @(posedge clk); while (hready !== 1'b1);
    d = hrdata;
  endtask

  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {2'h0, idx, 2'h0};
    wait_ready(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(rd);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, idx, wd, d);
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, idx, 32'h0, d);
    check($sformatf("reg_%h", idx), d, exp);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rd_chk(STS, 32'h0000_0008);
    rd_chk(ADL, 32'h0000_0001);
    rd_chk(ADM, 32'h0000_4010);
    rd_chk(CTL, 32'h0000_1000);
    rd_chk(12'h204, 32'h0000_0000);
  endtask

  task automatic t_adv;
    wr(ADL, 32'hFFFF_FFFF);
    rd_chk(ADL, 32'h0000_BC01);
    @(negedge clk);
    check("more_pages", 32'(advertise_more_pages), 32'h1);
    check("pause", 32'(advertise_pause), 32'h3);
    check("adv_fault", 32'(advertise_fault), 32'h1);
    check("forced_role", 32'(forced_role_select), 32'h1);
    wr(ADL, 32'h0000_0000);
    rd_chk(ADL, 32'h0000_0001);
    wr(ADM, 32'hFFFF_FFFF);
    rd_chk(ADM, 32'h0000_4010);
    wr(ADM, 32'h0000_0000);
    rd_chk(ADM, 32'h0000_0000);
    @(negedge clk);
    check("long_reach", 32'(advertise_long_reach_ability), 32'h0);
    check("nonce_low", 32'(nonce_role_bit), 32'h0);
    wr(ADM, 32'h0000_0010);
    @(negedge clk);
    check("nonce_high", 32'(nonce_role_bit), 32'h1);
    check("master_role", 32'(advertise_master_role), 32'h1);
    wr(STS, 32'hFFFF_FFFF);
    wr(12'h204, 32'hFFFF_FFFF);
    rd_chk(STS, 32'h0000_0008);
    // a byte-sized write must complete without touching the register
    hsize <= 3'h0;
    wr(ADL, 32'hFFFF_FFFF);
    hsize <= negotiation_pkg::HSIZE_WORD;
    check("hresp", 32'(hresp), 32'h0);
    rd_chk(ADL, 32'h0000_0001);
  endtask

  task automatic t_strap;
    master_role_strap <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(ADM, 32'h0000_4000);
    rd_chk(STS, 32'h0000_0028);
  endtask

  task automatic t_page;
    link_engine_model_inst.set_line(1'b0, 1'b1);
    rd_chk(STS, 32'h0000_0008);
    rd_chk(STS, 32'h0000_000C);
    link_engine_model_inst.give_page(1'b1, 1'b1);
    @(negedge clk);
    check("base_valid", 32'(partner_base_valid), 32'h1);
    check("ack", 32'(codeword_acknowledge), 32'h1);
    rd_chk(STS, 32'h0000_005C);
    rd_chk(STS, 32'h0000_000C);
    wr(ADL, 32'h0000_0000);
    rd_chk(ADL, 32'h0000_4001);
    link_engine_model_inst.give_page(1'b0, 1'b1);
    rd_chk(STS, 32'h0000_004C);
    link_engine_model_inst.new_attempt();
    @(negedge clk);
    check("base_cleared", 32'(partner_base_valid), 32'h0);
    link_engine_model_inst.give_page(1'b0, 1'b0);
    @(negedge clk);
    check("next_not_base", 32'(partner_base_valid), 32'h0);
    link_engine_model_inst.give_page(1'b1, 1'b0);
    @(negedge clk);
    check("base_again", 32'(partner_base_valid), 32'h1);
    rd_chk(STS, 32'h0000_004C);
  endtask

  task automatic t_done;
    link_engine_model_inst.set_line(1'b1, 1'b1);
    rd_chk(STS, 32'h0000_002C);
    wr(CTL, 32'h0000_0000);
    rd_chk(STS, 32'h0000_000C);
    @(negedge clk);
    check("enable_off", 32'(negotiation_enable), 32'h0);
    check("base_off", 32'(partner_base_valid), 32'h0);
    check("ack_off", 32'(codeword_acknowledge), 32'h0);
    wr(CTL, 32'h0000_1000);
    link_engine_model_inst.set_line(1'b1, 1'b0);
    link_engine_model_inst.set_line(1'b1, 1'b1);
    rd_chk(STS, 32'h0000_0028);
    rd_chk(STS, 32'h0000_002C);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // clock, watchdog, main sequence
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the full run needs under two hundred cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial
  begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = negotiation_pkg::HSIZE_WORD;
    master_role_strap = 1'b1;
    fail_count = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_adv();
    t_page();
    t_done();
    t_strap();
    give_verdict();
  end
endmodule
